// [inc/adc_ctrl_pkg.sv]
package adc_ctrl_pkg;
    localparam int unsigned clk_mhz = 200;            // ref_clk rate in MHz
    localparam int unsigned result_width = 8;         // converter resolution
    localparam logic [7:0] result_reset = 8'h00;      // result after reset
    localparam int unsigned run_bit_pos = 7;          // run bit in mode register
    localparam int unsigned enable_bit_pos = 0;       // enable bit in mode register
    localparam int unsigned sample_cycles = 8;        // sampling part of one conversion
    localparam int unsigned bit_cycles = 2;           // cycles per approximation step
    // total conversion time includes sampling, not added separately
    localparam int unsigned conv_cycles = sample_cycles + result_width * bit_cycles;
    typedef enum logic [1:0] {st_idle, st_convert, st_pend} conv_state_t;
endpackage

// [inc/result_if.sv]
`timescale 1ns/1ps
// write path into the result store: one strobe, one word, one read tap
interface result_if;
    logic we;           // write strobe
    logic [7:0] wdata;  // word to store
    logic [7:0] rdata;  // stored word (registered)
    modport ctrl (output we, output wdata, input rdata);
    modport store (input we, input wdata, output rdata);
endinterface

// [rtl/result_store.sv]
`timescale 1ns/1ps
module result_store
    import adc_ctrl_pkg::*;
(
    input wire logic ref_clk, // clock
    input wire logic srst,    // sync reset, high
    result_if.store port      // write and read path
);
    logic [7:0] next_word; // next stored value
    logic [7:0] word;      // stored result

    // hold unless strobed; reset clears the result
    always_comb begin
        next_word = port.we ? port.wdata : word;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            word <= result_reset; // RULE20
        end else begin
            word <= next_word;
        end
    end

    assign port.rdata = word;

    reset_clear_a: assert property (@(posedge ref_clk) srst |=> word == 8'h00) // RULE20
        else $error("result not cleared by reset");
endmodule

// [rtl/adc_conversion_control.sv]
`timescale 1ns/1ps
// Summary of operation
// RULE1: coinciding result read returns old value
// RULE2: new value written after colliding read
// RULE3: config write wins, result update dropped
// RULE4: no end request when result dropped
// RULE5: software clears run, enable before standby
// RULE6: software clears flag before restarting
// RULE7: channel rewrite leaves end flag alone
// RULE8: old-channel end may show after rewrite
// RULE9: clear flag before setting run again
// RULE10: early start first result discarded by software
// RULE11: config writes may disturb result contents
// RULE12: software reads result before config writes
// RULE13: software avoids shared port pins converting
// RULE14: no pin reassignment during conversion
// RULE15: light sleep after start recommended
// RULE16: conversion time includes sampling interval
// RULE17: store, request, restart while run set
// RULE18: channel rewrite restarts current conversion
// RULE19: run cleared stops, keeps old result
// RULE20: reset clears result to zero
// RULE21: end flag held until software clears
module adc_conversion_control
    import adc_ctrl_pkg::*;
(
    input wire logic ref_clk,                // clock, 200 MHz
    input wire logic srst,                   // sync reset, high
    input wire logic [7:0] mode_wdata,       // converter_mode_reg write data
    input wire logic mode_we,                // converter_mode_reg write strobe
    input wire logic channel_we,             // channel_select_reg write strobe
    input wire logic port_cfg_we,            // port_analog_config_reg write strobe
    input wire logic result_re,              // conversion_result_reg read strobe
    input wire logic flag_clear,             // software clear of end flag
    input wire logic [7:0] sar_value,        // comparator chain final word
    output logic conversion_run_bit,         // run bit state
    output logic converter_power_enable,     // enable bit state
    output logic converting,                 // conversion in progress
    output logic [7:0] conversion_result_reg, // result as read
    output logic conversion_end_request,     // one-cycle end pulse
    output logic conversion_end_flag         // sticky end flag
);
    logic run;           // run bit
    logic next_run;
    logic enable;        // enable bit
    logic next_enable;
    conv_state_t state;  // sequencer state
    conv_state_t next_state;
    logic [7:0] count;   // cycles left in conversion
    logic [7:0] next_count;
    logic [7:0] pend;    // value waiting behind a read
    logic [7:0] next_pend;
    logic req;           // end request pulse
    logic next_req;
    logic flag;          // sticky flag
    logic next_flag;
    logic [7:0] rd;      // read data register
    logic [7:0] next_rd;
    logic busy;          // registered copy of conversion in progress
    logic next_busy;
    logic cfg_wr;        // any config write this cycle
    logic done;          // conversion ends this cycle
    result_if res ();    // path to result store

    // the count register is 8 bits wide and needs at least two steps
    if (conv_cycles > 255 || conv_cycles < 2) begin : g_bad_len
        $error("conv_cycles out of range");
    end

    result_store u_store (
        .ref_clk(ref_clk),
        .srst(srst),
        .port(res.store)
    );

    assign cfg_wr = mode_we | channel_we | port_cfg_we;
    assign done = (state == st_convert) && (count == 8'h01);

    // sequencer and control bits
    always_comb begin
        next_run = run;
        next_enable = enable;
        next_state = state;
        next_count = count;
        next_pend = pend;
        next_req = 1'b0;
        res.we = 1'b0;
        res.wdata = sar_value;
        if (mode_we) begin
            next_run = mode_wdata[run_bit_pos];
            next_enable = mode_wdata[enable_bit_pos];
        end
        case (state)
            st_idle: begin
                if (next_run) begin
                    // a fresh run starts from sampling
                    next_state = st_convert;
                    next_count = 8'(conv_cycles); // RULE16
                end
            end
            st_convert: begin
                if (mode_we && !next_run) begin
                    // stop at once; stored result untouched
                    next_state = st_idle; // RULE19
                end else if (channel_we) begin
                    // abort and begin again on the new channel
                    next_count = 8'(conv_cycles); // RULE18
                end else if (done) begin
                    next_count = 8'(conv_cycles); // RULE17
                    if (cfg_wr) begin
                        // config write wins; word and request dropped
                        next_state = st_convert; // RULE3 RULE4 RULE11
                    end else if (result_re) begin
                        // read first, write the new word next cycle
                        next_pend = sar_value; // RULE1
                        next_state = st_pend;
                        next_req = 1'b1; // RULE17
                    end else begin
                        res.we = 1'b1; // RULE17
                        next_req = 1'b1;
                    end
                end else begin
                    next_count = count - 8'h01;
                end
            end
            st_pend: begin
                // late write of the word held behind a read
                res.we = 1'b1; // RULE2
                res.wdata = pend;
                next_state = next_run ? st_convert : st_idle;
                next_count = 8'(conv_cycles) - 8'h01;
            end
            default: next_state = st_idle;
        endcase
        // busy output is registered so it leaves the block from a flop
        next_busy = (next_state != st_idle);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            run <= 1'b0;
            enable <= 1'b0;
            state <= st_idle;
            count <= 8'h00;
            pend <= 8'h00;
            req <= 1'b0;
            busy <= 1'b0;
        end else begin
            run <= next_run;
            enable <= next_enable;
            state <= next_state;
            count <= next_count;
            pend <= next_pend;
            req <= next_req;
            busy <= next_busy;
        end
    end

    // flag and read data; set beats clear, channel writes do not touch it
    always_comb begin
        next_flag = flag;
        if (flag_clear) begin
            next_flag = 1'b0; // RULE21
        end
        if (next_req) begin
            next_flag = 1'b1; // RULE7 RULE8
        end
        // read data follows the store; pending word lands a cycle later
        next_rd = res.we ? res.wdata : res.rdata; // RULE1
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flag <= 1'b0;
            rd <= result_reset; // RULE20
        end else begin
            flag <= next_flag;
            rd <= next_rd;
        end
    end

    assign conversion_run_bit = run;
    assign converter_power_enable = enable;
    assign converting = busy;
    assign conversion_end_request = req;
    assign conversion_end_flag = flag;
    assign conversion_result_reg = rd;

    sequence collide_cfg_s;
        done && cfg_wr && !(mode_we && !next_run);
    endsequence
    sequence collide_read_s;
        done && result_re && !cfg_wr;
    endsequence

    drop_on_cfg_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE3
        collide_cfg_s |=> !req && $stable(res.rdata))
        else $error("config collision still updated result");
    no_req_cfg_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE4
        collide_cfg_s |=> !conversion_end_request)
        else $error("request raised for dropped result");
    read_old_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE1
        collide_read_s |=> conversion_result_reg == $past(res.rdata))
        else $error("colliding read saw new value");
    late_write_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE2
        collide_read_s |=> ##1 res.rdata == $past(sar_value, 2))
        else $error("pending word not written");
    flag_sticky_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE21
        flag && !flag_clear |=> flag)
        else $error("flag dropped without clear");
    chan_flag_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE7
        channel_we && flag && !flag_clear |=> flag)
        else $error("channel write cleared flag");
    stop_now_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE19
        state == st_convert && mode_we && !mode_wdata[run_bit_pos]
        |=> state == st_idle ##1 $stable(res.rdata))
        else $error("stop not immediate");
    restart_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE18
        state == st_convert && channel_we && run && !mode_we
        |=> count == 8'(conv_cycles))
        else $error("channel write did not restart");
    cont_run_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE17
        done && !cfg_wr && !result_re |=> req && state == st_convert)
        else $error("no request or no next conversion");
    conv_len_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE16
        state == st_idle && mode_we && mode_wdata[run_bit_pos]
        |=> count == 8'(conv_cycles))
        else $error("conversion length wrong");
endmodule

// [verification/analog_source.sv]
`timescale 1ns/1ps
// analog pin model: input settles one clock after the bench moves it
module analog_source (
    input wire logic ref_clk, // clock
    input wire logic [7:0] level, // wanted input level
    output logic [7:0] sar_value // word the comparator chain settles to
);
    // pins stay analog, never touched as digital ports mid-conversion
    always_ff @(posedge ref_clk) begin
        sar_value <= level;
    end
endmodule

// [verification/tb_adc_conversion_control.sv]
`timescale 1ns/1ps
module tb_adc_conversion_control;
    import adc_ctrl_pkg::*;
    logic ref_clk = 1'b0; // 200 MHz
    logic srst = 1'b1; // held 8 cycles
    logic [7:0] mode_wdata = 8'h00; // mode write data
    logic mode_we = 1'b0, channel_we = 1'b0, port_cfg_we = 1'b0; // write strobes
    logic result_re = 1'b0, flag_clear = 1'b0; // read and clear strobes
    logic [7:0] level = 8'h00, sar_value, conversion_result_reg, old; // data
    logic conversion_run_bit, converter_power_enable, converting; // state
    logic conversion_end_request, conversion_end_flag; // end events
    logic [15:0] seed = 16'hcf3d; // lfsr state
    logic [4:0] hit [3] = '{5'h10, 5'h08, 5'h04}; // colliding writes
    int n_errors = 0, n_compared = 0, n, p;

    adc_conversion_control uut (.ref_clk(ref_clk), .srst(srst), .mode_wdata(mode_wdata),
        .mode_we(mode_we), .channel_we(channel_we), .port_cfg_we(port_cfg_we),
        .result_re(result_re), .flag_clear(flag_clear), .sar_value(sar_value),
        .conversion_run_bit(conversion_run_bit), .converting(converting),
        .converter_power_enable(converter_power_enable),
        .conversion_result_reg(conversion_result_reg),
        .conversion_end_request(conversion_end_request),
        .conversion_end_flag(conversion_end_flag));
    analog_source src (.ref_clk(ref_clk), .level(level), .sar_value(sar_value));

    // maximal-length 16-bit shift register
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // edges from the one that takes a run or channel write to the end pulse
    // sampling is part of the conversion, so nothing is added for it
    function automatic int latency();
        return conv_cycles;
    endfunction

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task stop_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one-cycle strobe set {mode, channel, port, read, clear}
    task drive(input logic [7:0] md, input logic [4:0] s);
        @(posedge ref_clk);
        mode_wdata <= md;
        {mode_we, channel_we, port_cfg_we, result_re, flag_clear} <= s;
        @(posedge ref_clk);
        {mode_we, channel_we, port_cfg_we, result_re, flag_clear} <= 5'h00;
    endtask

    // edges until the end pulse; zero if none within lim
    task wait_req(input int lim, input bit must, output int cnt);
        cnt = 0;
        for (int i = 1; i <= lim && cnt == 0; i++) begin
            @(posedge ref_clk);
            #1;
            if (conversion_end_request === 1'b1) cnt = i;
        end
        if (must && cnt == 0) begin
            n_errors++;
            stop_test();
        end
    endtask

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        check("result", conversion_result_reg, result_reset);
        check("flag", conversion_end_flag, 1'b0);
        // run with enable at once: first word is not trusted
        drive(8'h81, 5'h10);
        // the bench stays idle right after the start, as a sleeping core would
        wait_req(100, 1, n);
        check("latency", n, latency());
        // back-to-back conversions on random levels
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            level = seed[7:0];
            wait_req(100, 1, p);
            check("period", p, latency());
            check("result", conversion_result_reg, level);
            check("running", converting, 1'b1);
        end
        // read landing on the end edge: old word first, new one next
        old = level;
        wait_req(100, 1, n);
        level = ~old;
        // read strobe taken at the edge that ends the next conversion
        repeat (conv_cycles - 2) @(posedge ref_clk);
        drive(8'h00, 5'h02);
        #1;
        check("old word", conversion_result_reg, old);
        check("end pulse", conversion_end_request, 1'b1);
        wait_req(2, 0, n);
        check("single pulse", n, 0);
        check("new word", conversion_result_reg, level);
        // configuration writes landing on the end edge drop the end
        foreach (hit[j]) begin
            wait_req(100, 1, n);
            drive(8'h00, 5'h01);
            // write strobe taken at the edge that ends the next conversion
            repeat (conv_cycles - 4) @(posedge ref_clk);
            drive(8'h81, hit[j]);
            wait_req(3, 0, n);
            check("dropped pulse", n, 0);
            check("dropped flag", conversion_end_flag, 1'b0);
        end
        // channel rewrite mid-conversion keeps the flag, restarts count
        wait_req(100, 1, n);
        repeat (5) @(posedge ref_clk);
        drive(8'h00, 5'h08);
        #1;
        check("flag kept", conversion_end_flag, 1'b1);
        wait_req(100, 1, n);
        check("restart", n, latency());
        repeat (2) @(posedge ref_clk);
        #1;
        old = conversion_result_reg;
        // stop mid-conversion, clearing run and enable for standby
        repeat (5) @(posedge ref_clk);
        drive(8'h00, 5'h10);
        #1;
        check("stopped", converting, 1'b0);
        check("run", {conversion_run_bit, converter_power_enable}, 2'b00);
        wait_req(40, 0, n);
        check("no pulse", n, 0);
        check("kept", conversion_result_reg, old);
        // clear the flag before resuming
        drive(8'h00, 5'h01);
        #1;
        check("cleared", conversion_end_flag, 1'b0);
        drive(8'h81, 5'h10);
        wait_req(100, 1, n);
        check("resume", n, latency());
        stop_test();
    end
endmodule
